/* pobac_pkg.sv */
// Purpose: Constants for the second-output action control block.
// Assumes: Avalon-MM word addressing by byte address, 32-bit data.
// Notes: One action register per channel.
package pobac_pkg;
  localparam int NUM_CHAN = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_CHAN0_B_ACTION = 8'h64;
  localparam logic [7:0] OFF_CHAN1_B_ACTION = 8'hA4;
  localparam logic [7:0] OFF_CHAN2_B_ACTION = 8'hE4;
  localparam logic [7:0] OFF_MODE_CTRL = 8'hF0;
  localparam logic [7:0] OFF_OUT_STATUS = 8'hF4;
  // Field positions (low bit)
  localparam int FLD_ZERO = 0;
  localparam int FLD_LOAD = 2;
  localparam int FLD_CMPA_UP = 4;
  localparam int FLD_CMPA_DN = 6;
  localparam int FLD_CMPB_UP = 8;
  localparam int FLD_CMPB_DN = 10;
  localparam int ACTION_BITS = 12;
  localparam logic [11:0] ACTION_RESET = 12'h000;
  localparam logic [NUM_CHAN-1:0] MODE_RESET = 3'h0;
  // Action encodings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
endpackage

/* pobac_apply.sv */
// Purpose: Applies one channel's event actions to its second output.
// Assumes: Event inputs are one-cycle pulses.
// Notes: Purely combinational.
`timescale 1ns/1ns
module pobac_apply (
  input wire logic [pobac_pkg::ACTION_BITS-1:0] i_action,
  input wire logic i_updown_mode,
  input wire logic i_zero,
  input wire logic i_load,
  input wire logic i_cmp_a,
  input wire logic i_cmp_b,
  input wire logic i_count_up,
  input wire logic i_cur,
  output logic o_next
);
  import pobac_pkg::*;

  function automatic logic do_action(input logic [1:0] act, input logic cur);
    case (act)
      ACT_TOGGLE: do_action = ~cur;
      ACT_LOW: do_action = 1'b0;
      ACT_HIGH: do_action = 1'b1;
      default: do_action = cur;
    endcase
  endfunction

  logic up_ok;
  logic [1:0] act_sel;

  always_comb begin
    // Up-count matches only exist in up/down mode
    up_ok = i_updown_mode & i_count_up; // see RULE2 see RULE8
    act_sel = ACT_NONE;
    if (i_zero | i_load) begin // see RULE4
      act_sel = i_zero ? i_action[FLD_ZERO +: 2] : i_action[FLD_LOAD +: 2];
    end else if (i_cmp_b) begin // see RULE5
      if (up_ok) begin
        act_sel = i_action[FLD_CMPB_UP +: 2];
      end else if (!i_count_up) begin
        act_sel = i_action[FLD_CMPB_DN +: 2]; // see RULE6
      end
    end else if (i_cmp_a) begin
      if (up_ok) begin
        act_sel = i_action[FLD_CMPA_UP +: 2];
      end else if (!i_count_up) begin
        act_sel = i_action[FLD_CMPA_DN +: 2];
      end
    end
    o_next = do_action(act_sel, i_cur); // see RULE7 see RULE1
  end
endmodule

/* pobac_top.sv */
// Purpose: Second-output action control for three generator channels.
// Assumes: Event pulses are synchronous to i_core_clk.
// Notes: Registers on Avalon-MM, one wait state on every access.
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - Output driven by zero, load, cmpA, cmpB
// RULE2 - Down mode four events; up/down six
// RULE3 - One action register per channel
// RULE4 - Zero/load beats compare on coincidence
// RULE5 - Compare B beats compare A
// RULE6 - Bits 11:10 compare B down; rest zero
// RULE7 - Codes: keep, toggle, low, high
// RULE8 - Up-count actions only in up/down mode
// RULE9 - Field layout, read/write, reset zero
module pobac_top (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [pobac_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [pobac_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [pobac_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [pobac_pkg::NUM_CHAN-1:0] i_zero_event,
  input wire logic [pobac_pkg::NUM_CHAN-1:0] i_load_event,
  input wire logic [pobac_pkg::NUM_CHAN-1:0] i_cmp_a_event,
  input wire logic [pobac_pkg::NUM_CHAN-1:0] i_cmp_b_event,
  input wire logic [pobac_pkg::NUM_CHAN-1:0] i_count_up,
  output logic [pobac_pkg::NUM_CHAN-1:0] o_channel_second_output
);
  import pobac_pkg::*;

  // Bus handshake phase, one-hot
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b01,
    PHASE_ANSWER = 2'b10
  } pobac_phase_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0][ACTION_BITS-1:0] action;
    logic [NUM_CHAN-1:0] updown_mode;
    logic [NUM_CHAN-1:0] outp;
    pobac_phase_t phase;
    logic [DATA_W-1:0] rdata;
  } pobac_state_t;

  pobac_state_t state_reg;
  pobac_state_t state_next;
  logic [NUM_CHAN-1:0] out_next;
  logic req;
  logic [NUM_CHAN-1:0] chan_hit;
  logic [NUM_CHAN-1:0] chan_wr;
  logic mode_hit;
  logic status_hit;
  logic wr_take;
  logic rd_take;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic [7:0] chan_offset(input int c);
    case (c)
      0: chan_offset = OFF_CHAN0_B_ACTION;
      1: chan_offset = OFF_CHAN1_B_ACTION;
      default: chan_offset = OFF_CHAN2_B_ACTION;
    endcase
  endfunction

  // One-hot channel select from a byte address
  function automatic logic [NUM_CHAN-1:0] chan_decode(
    input logic [ADDR_W-1:0] addr
  );
    chan_decode = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (addr == chan_offset(c)) begin
        chan_decode[c] = 1'b1;
      end
    end
  endfunction

  // Lane merge; lanes 2 and 3 have no storage
  function automatic logic [ACTION_BITS-1:0] lane_merge(
    input logic [ACTION_BITS-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [3:0] be
  );
    lane_merge = old_val;
    if (be[0]) begin
      lane_merge[7:0] = wdata[7:0]; // see RULE9
    end
    if (be[1]) begin
      lane_merge[ACTION_BITS-1:8] = wdata[ACTION_BITS-1:8]; // see RULE6
    end
  endfunction

  // Zero-extends a per-channel bit image
  function automatic logic [DATA_W-1:0] widen_chan(
    input logic [NUM_CHAN-1:0] v
  );
    widen_chan = {{(DATA_W-NUM_CHAN){1'b0}}, v};
  endfunction

  // Read image; unmapped addresses read zero
  function automatic logic [DATA_W-1:0] read_image(
    input logic [NUM_CHAN-1:0] hit,
    input logic mode_sel,
    input logic status_sel,
    input pobac_state_t s
  );
    read_image = '0;
    // Reserved upper bits always zero
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (hit[c]) begin
        read_image = {{(DATA_W-ACTION_BITS){1'b0}}, s.action[c]};
      end
    end
    if (mode_sel) begin
      read_image = widen_chan(s.updown_mode);
    end
    if (status_sel) begin
      read_image = widen_chan(s.outp);
    end
  endfunction

  // State after reset: all fields zero, bus idle
  function automatic pobac_state_t reset_image();
    pobac_state_t s;
    s = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      s.action[c] = ACTION_RESET; // see RULE9
    end
    s.updown_mode = MODE_RESET;
    s.outp = '0;
    s.phase = PHASE_IDLE;
    s.rdata = '0;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel action logic
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      pobac_apply u_apply (
        .i_action(state_reg.action[g]), // see RULE3
        .i_updown_mode(state_reg.updown_mode[g]),
        .i_zero(i_zero_event[g]),
        .i_load(i_load_event[g]),
        .i_cmp_a(i_cmp_a_event[g]),
        .i_cmp_b(i_cmp_b_event[g]),
        .i_count_up(i_count_up[g]),
        .i_cur(state_reg.outp[g]),
        .o_next(out_next[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and bus qualifiers
  assign chan_hit = chan_decode(i_avs_address);
  assign mode_hit = (i_avs_address == OFF_MODE_CTRL);
  assign status_hit = (i_avs_address == OFF_OUT_STATUS);
  assign req = (i_avs_read | i_avs_write) &
    (state_reg.phase != PHASE_ANSWER);
  // Read data loads on the waited edge
  assign rd_take = req & i_avs_read;
  // Writes land on the edge where waitrequest is seen low
  assign wr_take = i_avs_write & (state_reg.phase == PHASE_ANSWER);

  // Per-channel write strobes
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_wr
      assign chan_wr[g] = wr_take & chan_hit[g]; // see RULE3
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register file and state update
  always_comb begin
    state_next = state_reg;
    state_next.outp = out_next; // see RULE1
    // Handshake: one wait state, then a single answer cycle
    case (state_reg.phase)
      PHASE_IDLE: begin
        state_next.phase = req ? PHASE_ANSWER : PHASE_IDLE;
      end
      PHASE_ANSWER: begin
        state_next.phase = PHASE_IDLE;
      end
      default: begin
        state_next.phase = PHASE_IDLE;
      end
    endcase
    // Action fields, masked by byte lanes
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (chan_wr[c]) begin
        state_next.action[c] = lane_merge(state_reg.action[c],
                                          i_avs_writedata,
                                          i_avs_byteenable);
      end
    end
    // Counting-mode bits, one per channel
    if (wr_take & mode_hit & i_avs_byteenable[0]) begin
      state_next.updown_mode = i_avs_writedata[NUM_CHAN-1:0]; // see RULE8
    end
    // Read data held until the next read
    if (rd_take) begin
      state_next.rdata = rd_mux;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= reset_image(); // see RULE9
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read path
  assign rd_mux = read_image(chan_hit, mode_hit, status_hit, state_reg);
  // Combinational wait: high for a request not yet in its answer cycle
  assign o_avs_waitrequest = req;
  assign o_avs_readdata = state_reg.rdata;
  assign o_channel_second_output = state_reg.outp;
endmodule

/* pobac_properties.sv */
// Purpose: Port assertions for pobac_top.
// Assumes: One clock, synchronous reset.
// Notes: Bound below.
`timescale 1ns/1ns
module pobac_props (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [2:0] i_zero_event,
  input wire logic [2:0] i_load_event,
  input wire logic [2:0] i_cmp_a_event,
  input wire logic [2:0] i_cmp_b_event,
  input wire logic [2:0] o_channel_second_output
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire [2:0] ev = i_zero_event | i_load_event | i_cmp_a_event | i_cmp_b_event;
  wire rq = i_avs_read | i_avs_write;
  wire [2:0] q = o_channel_second_output;
  sequence wait_s; rq && o_avs_waitrequest; endsequence
  sequence ack_s; rq && !o_avs_waitrequest; endsequence
  wait_ack_a: assert property (wait_s |=> ack_s) else $error("no ack");
  ack_wait_a: assert property (ack_s |-> $past(o_avs_waitrequest))
    else $error("ack without wait");
  idle_wait_a: assert property (!rq |-> !o_avs_waitrequest) else $error("wt");
  rsvd_zero_a: assert property (i_avs_read && !o_avs_waitrequest |->
    o_avs_readdata[31:12] == 20'h0) else $error("reserved bits set");
  rst_clear_a: assert property ($fell(i_reset) |-> q == 3'h0)
    else $error("output not cleared");
  hold_ch0_a: assert property (!ev[0] |=> $stable(q[0])) else $error("c0");
  hold_ch1_a: assert property (!ev[1] |=> $stable(q[1])) else $error("c1");
  hold_ch2_a: assert property (!ev[2] |=> $stable(q[2])) else $error("c2");
endmodule
bind pobac_top pobac_props u_props (.*);

/* test_pobac_top.sv */
// Purpose: Self-checking bench for pobac_top.
// Assumes: One wait state per bus access.
// Notes: Events are one-cycle pulses.
`timescale 1ns/1ns
module test_pobac_top;
  import pobac_pkg::*;
  logic clk = 1'h0, rst = 1'h1, rdq = 1'h0, wrq = 1'h0, wt;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic [2:0] ze = 3'h0, le = 3'h0, ae = 3'h0, be = 3'h0, up = 3'h0, q;
  int fails = 0, samples_checked = 0, cyc = 0;
  always #20 clk = ~clk;
  pobac_top DUT (.i_core_clk(clk), .i_reset(rst), .i_avs_address(adr),
    .i_avs_read(rdq), .i_avs_write(wrq), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
    .i_zero_event(ze), .i_load_event(le), .i_cmp_a_event(ae),
    .i_cmp_b_event(be), .i_count_up(up), .o_channel_second_output(q));
  task chk(input [31:0] s, input [31:0] e, input string n);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task bus(input bit r, input [7:0] a, input [31:0] d);
    @(posedge clk);
    rdq <= r;
    wrq <= !r;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wt);
    rd = rdat;
    rdq <= 1'h0;
    wrq <= 1'h0;
  endtask
  task ev(input [14:0] v);
    @(posedge clk);
    {up, ze, le, ae, be} <= v;
    @(posedge clk);
    {ze, le, ae, be} <= 12'h000;
    #1;
  endtask
  task t_regs;
    bus(1, OFF_CHAN0_B_ACTION, 32'h0);
    chk(rd, 32'h0, "reset");
    bus(0, OFF_CHAN1_B_ACTION, 32'hFFFFFFFF);
    bus(1, OFF_CHAN1_B_ACTION, 32'h0);
    chk(rd, 32'hFFF, "mask");
    $display("t_regs done");
  endtask
  task t_codes;
    logic [9:0] c;
    logic [4:0] e;
    c = {ACT_NONE, ACT_LOW, ACT_TOGGLE, ACT_TOGGLE, ACT_HIGH};
    e = 5'h05;
    for (int i = 0; i < 5; i++) begin
      bus(0, OFF_CHAN0_B_ACTION, {30'h0, c[2*i+:2]});
      ev(15'h0200);
      chk(q, {2'h0, e[i]}, "code");
    end
    $display("t_codes done");
  endtask
  task t_prio;
    bus(0, OFF_CHAN2_B_ACTION, 32'h8C3);
    ev(15'h0804);
    chk(q, 3'h4, "zero over b");
    ev(15'h0024);
    chk(q, 3'h0, "b over a");
    ev(15'h0020);
    chk(q, 3'h4, "a alone");
    ev(15'h0104);
    chk(q, 3'h4, "load over b");
    $display("t_prio done");
  endtask
  task t_mode;
    bus(0, OFF_CHAN1_B_ACTION, 32'h30);
    ev(15'h2010);
    chk(q, 3'h4, "up ignored");
    bus(0, OFF_MODE_CTRL, 32'h2);
    ev(15'h2010);
    chk(q, 3'h6, "up taken");
    $display("t_mode done");
  endtask
  task t_misc;
    bus(1, OFF_MODE_CTRL, 32'h0);
    chk(rd, 32'h2, "mode readback");
    bus(1, OFF_OUT_STATUS, 32'h0);
    chk(rd, 32'h6, "status");
    bus(0, OFF_CHAN0_B_ACTION, 32'h320);
    ev(15'h1001);
    chk(q, 3'h6, "b up ignored");
    bus(0, OFF_MODE_CTRL, 32'h3);
    ev(15'h1009);
    chk(q, 3'h7, "b up over a up");
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    chk(q, 3'h0, "reset out");
    bus(1, OFF_CHAN2_B_ACTION, 32'h0);
    chk(rd, 32'h0, "reset reg");
    $display("t_misc done");
  endtask
  task test_done;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_regs;
    t_codes;
    t_prio;
    t_mode;
    t_misc;
    test_done;
  end
endmodule
